// [rtl/diag_record_pkg.sv]
// package for the diagnostic data record of a two-channel analog input module
// assumes a single 125 MHz clock and byte-wide record reads
`default_nettype none
package diag_record_pkg;
	// ****************************************************
	// access selectors
	// ****************************************************
	localparam logic [7:0]  SET_SHORT      = 8'h00;
	localparam logic [7:0]  SET_FULL       = 8'h01;
	localparam logic [15:0] INDEX_SHORT    = 16'h2F00;
	localparam logic [15:0] INDEX_FULL     = 16'h2F01;
	localparam logic [15:0] ECAT_INDEX     = 16'h5005;
	localparam logic [7:0]  SUB_FIRST      = 8'h02;
	localparam logic [7:0]  SUB_LAST       = 8'h13;
	localparam logic [4:0]  SHORT_LEN      = 5'h04;
	localparam logic [4:0]  FULL_LEN       = 5'h14;
	// ****************************************************
	// byte positions in the record
	// ****************************************************
	localparam logic [4:0]  POS_SUMMARY    = 5'h00;
	localparam logic [4:0]  POS_INFO       = 5'h01;
	localparam logic [4:0]  POS_RSVD       = 5'h02;
	localparam logic [4:0]  POS_INTERNAL   = 5'h03;
	localparam logic [4:0]  POS_KIND       = 5'h04;
	localparam logic [4:0]  POS_BITS       = 5'h05;
	localparam logic [4:0]  POS_COUNT      = 5'h06;
	localparam logic [4:0]  POS_GROUPS     = 5'h07;
	localparam logic [4:0]  POS_CH0        = 5'h08;
	localparam logic [4:0]  POS_CH1        = 5'h09;
	localparam logic [4:0]  POS_STAMP      = 5'h10;
	// ****************************************************
	// fixed values
	// ****************************************************
	localparam logic [7:0]  MODULE_INFO_VAL = 8'h15;
	localparam logic [7:0]  KIND_VAL        = 8'h71;
	localparam logic [7:0]  BITS_VAL        = 8'h08;
	localparam logic [7:0]  COUNT_VAL       = 8'h02;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	// ****************************************************
	// bit positions
	// ****************************************************
	localparam int SUM_INTERNAL  = 1;
	localparam int SUM_EXTERNAL  = 2;
	localparam int SUM_CHANNEL   = 3;
	localparam int SUM_AUX       = 4;
	localparam int SUM_PARAM     = 7;
	localparam int INT_OVERFLOW  = 3;
	localparam int INT_COMM      = 4;
	localparam int INT_LOST      = 6;
	localparam int CH_CONFIG     = 0;
	localparam int CH_UNDER      = 5;
	localparam int CH_OVER       = 7;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_MHZ       = 125;
	localparam int TICK_US       = 1;
	localparam int TICK_CYCLES   = CLK_MHZ * TICK_US;
	// ****************************************************
	// carriers
	// ****************************************************
	typedef enum logic [1:0] {
		MODE_SET   = 2'h0,
		MODE_INDEX = 2'h1,
		MODE_SUB   = 2'h2
	} access_mode_t;

	typedef struct packed {
		logic         valid;
		access_mode_t mode;
		logic [15:0]  selector;
		logic [7:0]   sub;
		logic [4:0]   offset;
	} read_req_t;

	typedef struct packed {
		logic config_err;
		logic under;
		logic over;
	} chan_cause_t;

	typedef struct packed {
		logic        internal_err;
		logic        external_err;
		logic        aux_missing;
		logic        param_err;
		logic        diag_overflow;
		logic        comm_err;
		logic        irq_lost;
		chan_cause_t ch0;
		chan_cause_t ch1;
	} causes_t;
endpackage
`default_nettype wire

// [rtl/analog_input_diag_record.sv]
// diagnostic data record: status bytes, identity bytes and microsecond stamp
// assumes error causes are synchronous levels and one read request at a time
//
// Functional notes
// (RULE1) record set 01h reads the whole record, 00h only its first four bytes
// (RULE2) index 2F01h reads the whole record, 2F00h only its first four bytes
// (RULE3) diagnostic bits per channel byte reads 08h
// (RULE4) channel count byte reads 02h
// (RULE5) channel 0 error byte, zero by default
// (RULE6) channel 1 error byte zero by default; six reserved zero bytes follow
// (RULE7) summary bit 1 set while an internal error is present
// (RULE8) summary bit 2 on external error, bit 3 on any channel error
// (RULE9) summary bit 4 on missing aux supply, bit 7 on parameter error
// (RULE10) module info low nibble is class 0101b, bits 7 to 5 zero
// (RULE11) module info bit 4 marks channel information present
// (RULE12) internal flags bit 3 on diagnostics buffer overflow
// (RULE13) internal flags bit 4 on internal communication error
// (RULE14) internal flags bit 6 on lost process interrupt
// (RULE15) free 32-bit microsecond counter captured when a diagnostic appears while none is present
// (RULE16) group error byte bit 0 for group 0, bit 1 for group 1
// (RULE17) channel byte bit 0 on config error, bit 7 on range overflow
// (RULE18) error bits follow their causes and clear when causes go
`default_nettype none
module analog_input_diag_record
	import diag_record_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input  wire logic                      CLK,       // 125 MHz clock
	input  wire logic                      RESET_N,   // async reset, active low
	input  wire diag_record_pkg::read_req_t REQ,      // record byte read request
	input  wire diag_record_pkg::causes_t   CAUSES,   // live error causes
	output var  logic                      RD_VALID,  // read answer valid pulse
	output var  logic                      RD_ERROR,  // request out of range pulse
	output var  logic [7:0]                RD_DATA,   // read byte
	output var  logic                      DIAG_ACTIVE, // any error present
	output var  logic [31:0]               US_TIME    // microsecond counter
);
	import diag_record_pkg::*;

	// divider counter is 16 bits wide
	if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_tick_div
		$error("TICK_DIV out of range");
	end

	// ****************************************************
	// microsecond ticker
	// ****************************************************
	logic [15:0] div_reg;
	logic        tick;
	logic [31:0] us_reg;

	assign tick = (div_reg == 16'(TICK_DIV - 1));

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_reg <= 16'h0000;
		end else if (tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// wraps to zero past all ones
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			us_reg <= 32'h0000_0000;
		end else if (tick) begin
			us_reg <= us_reg + 32'h0000_0001; // RULE15
		end
	end

	// ****************************************************
	// status bytes, live from causes
	// ****************************************************
	logic [7:0] ch0_reg;
	logic [7:0] ch1_reg;
	logic [7:0] groups_reg;
	logic [7:0] summary_reg;
	logic [7:0] internal_reg;
	logic [7:0] ch0_next;
	logic [7:0] ch1_next;
	logic [7:0] groups_next;
	logic [7:0] summary_next;
	logic [7:0] internal_next;

	function automatic logic [7:0] chan_byte(input chan_cause_t c);
		logic [7:0] b;
		b = ZERO_BYTE;
		b[CH_CONFIG] = c.config_err; // RULE17
		b[CH_UNDER]  = c.under;
		b[CH_OVER]   = c.over;       // RULE17
		return b;
	endfunction

	always_comb begin
		ch0_next = chan_byte(CAUSES.ch0);              // RULE5
		ch1_next = chan_byte(CAUSES.ch1);              // RULE6
		groups_next = ZERO_BYTE;
		groups_next[0] = |ch0_next;                    // RULE16
		groups_next[1] = |ch1_next;                    // RULE16
		summary_next = ZERO_BYTE;
		summary_next[SUM_INTERNAL] = CAUSES.internal_err; // RULE7
		summary_next[SUM_EXTERNAL] = CAUSES.external_err; // RULE8
		summary_next[SUM_CHANNEL]  = |groups_next;        // RULE8
		summary_next[SUM_AUX]      = CAUSES.aux_missing;  // RULE9
		summary_next[SUM_PARAM]    = CAUSES.param_err;    // RULE9
		internal_next = ZERO_BYTE;
		internal_next[INT_OVERFLOW] = CAUSES.diag_overflow; // RULE12
		internal_next[INT_COMM]     = CAUSES.comm_err;      // RULE13
		internal_next[INT_LOST]     = CAUSES.irq_lost;      // RULE14
	end

	// no latching: each byte tracks its cause
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ch0_reg      <= ZERO_BYTE;
			ch1_reg      <= ZERO_BYTE;
			groups_reg   <= ZERO_BYTE;
			summary_reg  <= ZERO_BYTE;
			internal_reg <= ZERO_BYTE;
		end else begin
			ch0_reg      <= ch0_next;      // RULE18
			ch1_reg      <= ch1_next;      // RULE18
			groups_reg   <= groups_next;   // RULE18
			summary_reg  <= summary_next;  // RULE18
			internal_reg <= internal_next; // RULE18
		end
	end

	// ****************************************************
	// event timestamp
	// ****************************************************
	logic        active_reg;
	logic [31:0] stamp_reg;
	logic        any_next;

	assign any_next = (|summary_next) | (|internal_next);

	// capture when a diagnostic rises while none was present
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			active_reg <= 1'b0;
			stamp_reg  <= 32'h0000_0000;
		end else begin
			active_reg <= any_next;
			if (any_next && !active_reg) begin
				stamp_reg <= us_reg; // RULE15
			end
		end
	end

	// ****************************************************
	// record read
	// ****************************************************
	logic [4:0] rec_len;
	logic [4:0] rec_pos;
	logic       sel_ok;

	always_comb begin
		rec_len = FULL_LEN;
		rec_pos = REQ.offset;
		sel_ok  = 1'b0;
		case (REQ.mode)
			MODE_SET: begin
				sel_ok  = (REQ.selector == {8'h00, SET_FULL}) ||
					(REQ.selector == {8'h00, SET_SHORT}); // RULE1
				rec_len = (REQ.selector == {8'h00, SET_SHORT}) ? SHORT_LEN : FULL_LEN;
			end
			MODE_INDEX: begin
				sel_ok  = (REQ.selector == INDEX_FULL) ||
					(REQ.selector == INDEX_SHORT); // RULE2
				rec_len = (REQ.selector == INDEX_SHORT) ? SHORT_LEN : FULL_LEN;
			end
			MODE_SUB: begin
				sel_ok  = (REQ.selector == ECAT_INDEX) &&
					(REQ.sub >= SUB_FIRST) && (REQ.sub <= SUB_LAST);
				rec_pos = 5'(REQ.sub - SUB_FIRST);
			end
			default: begin
				sel_ok = 1'b0;
			end
		endcase
	end

	function automatic logic [7:0] rec_byte(input logic [4:0] p);
		logic [7:0] b;
		b = ZERO_BYTE;
		case (p)
			POS_SUMMARY:  b = summary_reg;
			POS_INFO:     b = MODULE_INFO_VAL; // RULE10 RULE11
			POS_INTERNAL: b = internal_reg;
			POS_KIND:     b = KIND_VAL;
			POS_BITS:     b = BITS_VAL;        // RULE3
			POS_COUNT:    b = COUNT_VAL;       // RULE4
			POS_GROUPS:   b = groups_reg;
			POS_CH0:      b = ch0_reg;
			POS_CH1:      b = ch1_reg;
			POS_STAMP:    b = stamp_reg[7:0];
			POS_STAMP + 5'h01: b = stamp_reg[15:8];
			POS_STAMP + 5'h02: b = stamp_reg[23:16];
			POS_STAMP + 5'h03: b = stamp_reg[31:24];
			default:      b = ZERO_BYTE;       // RULE6
		endcase
		return b;
	endfunction

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RD_VALID <= 1'b0;
			RD_ERROR <= 1'b0;
			RD_DATA  <= ZERO_BYTE;
		end else begin
			RD_VALID <= REQ.valid;
			RD_ERROR <= REQ.valid && !(sel_ok && rec_pos < rec_len);
			if (REQ.valid && sel_ok && rec_pos < rec_len) begin
				RD_DATA <= rec_byte(rec_pos);
			end else begin
				RD_DATA <= ZERO_BYTE;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DIAG_ACTIVE <= 1'b0;
			US_TIME     <= 32'h0000_0000;
		end else begin
			DIAG_ACTIVE <= active_reg;
			US_TIME     <= us_reg;
		end
	end

endmodule
`default_nettype wire

// [verif/diag_host_model.sv]
// host model: reads record bytes one request at a time
// assumes the record block answers with a one-cycle valid pulse
`default_nettype none
module diag_host_model
	import diag_record_pkg::*;
(
	input  wire logic                       CLK,      // clock
	input  wire logic                       RD_VALID, // answer pulse
	input  wire logic                       RD_ERROR, // refusal flag
	input  wire logic [7:0]                 RD_DATA,  // answer byte
	output var  diag_record_pkg::read_req_t REQ       // request to device
);
	timeunit 1ns;
	timeprecision 1ps;
	initial REQ = '0;
	task automatic rd(input access_mode_t m, input logic [15:0] s, input logic [4:0] b,
		output logic [7:0] d, output logic e);
		int n;
		@(posedge CLK);
		REQ <= '{1'b1, m, s, {3'h0, b} + 8'h02, b};
		@(posedge CLK);
		// idle fields toggle so stale values are never mistaken for live ones
		REQ <= '{1'b0, m, ~s, ~{3'h0, b}, ~b};
		#1;
		for (n = 0; n < 4 && RD_VALID !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		d = RD_DATA;
		e = (RD_VALID === 1'b1) ? RD_ERROR : 1'bx;
	endtask
endmodule
`default_nettype wire

// [verif/analog_input_diag_record_props.sv]
// checker for the diagnostic record read port
// assumes binding onto the record block's top ports
`default_nettype none
module analog_input_diag_record_props
	import diag_record_pkg::*;
(
	input wire logic                       CLK,         // clock
	input wire logic                       RESET_N,     // reset
	input wire diag_record_pkg::read_req_t REQ,         // request
	input wire diag_record_pkg::causes_t   CAUSES,      // causes
	input wire logic                       RD_VALID,    // answer pulse
	input wire logic                       RD_ERROR,    // refusal
	input wire logic [7:0]                 RD_DATA,     // byte
	input wire logic                       DIAG_ACTIVE, // any error
	input wire logic [31:0]                US_TIME      // ticker
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_full(logic [4:0] p);
		REQ.valid && REQ.mode == MODE_SET && REQ.selector == 16'h0001 && REQ.offset == p;
	endsequence
	a_answer_follows: assert property (REQ.valid |=> RD_VALID)
		else $error("read not answered");
	a_short_refused: assert property (REQ.valid && REQ.mode == MODE_SET &&
		REQ.selector == 16'h0000 && REQ.offset >= 5'h04 |=> RD_ERROR && RD_DATA == 8'h00)
		else $error("short set past byte 3 not refused");
	a_index_full_ok: assert property (REQ.valid && REQ.mode == MODE_INDEX &&
		REQ.selector == 16'h2F01 && REQ.offset < 5'h14 |=> !RD_ERROR)
		else $error("full index read refused");
	a_bits_value: assert property (s_full(5'h05) |=> RD_DATA == 8'h08)
		else $error("bits per channel wrong");
	a_count_value: assert property (s_full(5'h06) |=> RD_DATA == 8'h02)
		else $error("channel count wrong");
	a_info_value: assert property (s_full(5'h01) |=> RD_DATA == 8'h15)
		else $error("module info wrong");
	a_rsvd_zero: assert property (REQ.valid && REQ.mode == MODE_SET &&
		REQ.selector == 16'h0001 && REQ.offset inside {[5'h0A:5'h0F]} |=> RD_DATA == 8'h00)
		else $error("reserved channel byte not zero");
	a_internal_tracks: assert property (
		s_full(5'h00) |=> RD_DATA[1] == $past(CAUSES.internal_err, 2))
		else $error("internal error bit does not follow cause");
	a_lost_tracks: assert property (
		s_full(5'h03) |=> RD_DATA[6] == $past(CAUSES.irq_lost, 2))
		else $error("lost interrupt bit does not follow cause");
	a_ticker_steps: assert property (
		$stable(US_TIME) || US_TIME == $past(US_TIME) + 32'h1)
		else $error("ticker jumped");
endmodule
`default_nettype wire

// [verif/analog_input_diag_record_tb_top.sv]
// self-checking bench for the diagnostic record block
// assumes the host model drives all read requests
`default_nettype none
module analog_input_diag_record_tb_top
	import diag_record_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK, RESET_N, RD_VALID, RD_ERROR, DIAG_ACTIVE;
	read_req_t   REQ;
	causes_t     CAUSES;
	logic [7:0]  RD_DATA;
	logic [31:0] US_TIME, cyc;
	int          err_total = 0;
	int          checked = 0;
	logic [7:0]  tbl [16] = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h02, default: 8'h00};
	int          ks [13] = '{12, 11, 10, 9, 8, 7, 6, 5, 3, 0, 0, 5, 0};
	logic [4:0]  ps [13] = '{0, 0, 0, 0, 3, 3, 3, 8, 8, 9, 7, 7, 0};
	logic [7:0]  vs [13] = '{2, 4, 16, 128, 8, 16, 64, 1, 128, 128, 2, 1, 8};
	// ****************************************************
	// clock, design and host
	// ****************************************************
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	analog_input_diag_record #(.TICK_DIV(1)) uut (.CLK(CLK), .RESET_N(RESET_N), .REQ(REQ),
		.CAUSES(CAUSES), .RD_VALID(RD_VALID), .RD_ERROR(RD_ERROR), .RD_DATA(RD_DATA),
		.DIAG_ACTIVE(DIAG_ACTIVE), .US_TIME(US_TIME));
	diag_host_model host (.CLK(CLK), .RD_VALID(RD_VALID), .RD_ERROR(RD_ERROR),
		.RD_DATA(RD_DATA), .REQ(REQ));
	always @(posedge CLK or negedge RESET_N)
		if (!RESET_N) cyc <= '0;
		else cyc <= cyc + 32'h1;
	// ****************************************************
	// checks and scenarios
	// ****************************************************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_near(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if ((g >= e - 32'h2 && g <= e + 32'h6) !== 1'b1) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(access_mode_t m, logic [15:0] s, logic [4:0] b, logic [7:0] x, logic f);
		logic [7:0] d;
		logic       e;
		host.rd(m, s, b, d, e);
		chk("byte", x, d);
		chk("error", {7'h0, f}, {7'h0, e});
	endtask
	task automatic t_ident();
		for (int i = 0; i < 16; i++) begin
			rdc(MODE_SET, 16'h0001, i[4:0], tbl[i], 1'b0);
			rdc(MODE_INDEX, 16'h2F01, i[4:0], tbl[i], 1'b0);
			rdc(MODE_SUB, 16'h5005, i[4:0], tbl[i], 1'b0);
		end
	endtask
	task automatic t_short();
		for (int i = 0; i < 4; i++) begin
			rdc(MODE_SET, 16'h0000, i[4:0], tbl[i], 1'b0);
			rdc(MODE_INDEX, 16'h2F00, i[4:0], tbl[i], 1'b0);
		end
		rdc(MODE_SET, 16'h0000, 5'h04, 8'h00, 1'b1);
		rdc(MODE_INDEX, 16'h2F00, 5'h04, 8'h00, 1'b1);
		rdc(MODE_SET, 16'h0002, 5'h00, 8'h00, 1'b1);
		rdc(MODE_INDEX, 16'h2F02, 5'h00, 8'h00, 1'b1);
		rdc(MODE_SET, 16'h0001, 5'h14, 8'h00, 1'b1);
		rdc(MODE_SUB, 16'h5005, 5'h12, 8'h00, 1'b1);
	endtask
	task automatic t_causes();
		for (int i = 0; i < 13; i++) begin
			@(posedge CLK);
			CAUSES <= causes_t'(13'h1 << ks[i]);
			rdc(MODE_SET, 16'h0001, ps[i], vs[i], 1'b0);
			@(posedge CLK);
			CAUSES <= '0;
			rdc(MODE_SET, 16'h0001, ps[i], 8'h00, 1'b0);
		end
	endtask
	task automatic t_stamp();
		logic [31:0] t, st;
		logic [7:0]  d;
		logic        e;
		@(posedge CLK);
		CAUSES <= causes_t'(13'h0800);
		t = cyc;
		for (int i = 0; i < 4; i++) begin
			host.rd(MODE_SET, 16'h0001, 5'h10 + i[4:0], d, e);
			st[i*8 +: 8] = d;
		end
		chk_near("stamp", t, st);
		chk_near("ticker", cyc, US_TIME);
		chk("active", 8'h01, {7'h0, DIAG_ACTIVE});
		@(posedge CLK);
		CAUSES <= '0;
		repeat (3) @(posedge CLK);
		#1;
		chk("active_clear", 8'h00, {7'h0, DIAG_ACTIVE});
	endtask
	task automatic summarize();
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		RESET_N = 1'b0;
		CAUSES = '0;
		repeat (5) @(posedge CLK);
		RESET_N <= 1'b1;
		t_ident();
		t_short();
		t_causes();
		t_stamp();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		err_total++;
		summarize();
	end
endmodule
bind analog_input_diag_record analog_input_diag_record_props chk_i (.CLK(CLK),
	.RESET_N(RESET_N), .REQ(REQ), .CAUSES(CAUSES), .RD_VALID(RD_VALID), .RD_ERROR(RD_ERROR),
	.RD_DATA(RD_DATA), .DIAG_ACTIVE(DIAG_ACTIVE), .US_TIME(US_TIME));
`default_nettype wire
